// *** scd_pkg.sv ***
// Package with register map, field layout, reset values and state types of the clock select divider.
`default_nettype none
package scd_pkg;
  localparam logic [7:0] SCD_ADDR_SELECT_DIVIDE = 8'ha9;
  localparam logic [7:0] SCD_ADDR_EXT_OSC_CTRL = 8'hb1;
  localparam logic [7:0] SCD_ADDR_INT_OSC_CTRL = 8'hb2;
  localparam logic [7:0] SCD_ADDR_INT_OSC_TRIM = 8'hb3;
  localparam int SCD_POS_READY = 7;
  localparam int SCD_POS_DIV_LSB = 4;
  localparam int SCD_POS_OSC_ON = 7;
  localparam int SCD_POS_FREQ_OK = 6;
  localparam int SCD_POS_DITHER = 7;
  localparam int SCD_POS_EXT_VALID = 7;
  localparam int SCD_POS_EXT_MODE_LSB = 4;
  localparam logic [2:0] SCD_RST_DIV = 3'h3;
  localparam logic [2:0] SCD_RST_SRC = 3'h4;
  localparam logic [5:0] SCD_INT_CTRL_LOW_BITS = 6'h0f;
  localparam logic [2:0] SCD_SRC_PRECISION = 3'h0;
  localparam logic [2:0] SCD_SRC_EXTERNAL = 3'h1;
  localparam logic [2:0] SCD_SRC_RTC = 3'h3;
  localparam logic [2:0] SCD_SRC_LOW_POWER = 3'h4;
  localparam logic [2:0] SCD_EXT_MODE_RC = 3'h4;
  localparam logic [6:0] SCD_DIV_COUNT_LAST = 7'h7f;
  localparam int SCD_NUM_SRC = 4;

  typedef enum logic [1:0] {
    SCD_SW_RUN = 2'b00,
    SCD_SW_WAIT_OLD_LOW = 2'b01,
    SCD_SW_WAIT_NEW_LOW = 2'b10
  } scd_switch_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scd_sfr_req_s;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync_prev;
    logic [2:0] div_sel;
    logic [2:0] div_applied;
    logic ready;
    logic [2:0] src_code;
    logic [1:0] src_cur;
    logic [1:0] src_new;
    scd_switch_e sw_state;
    logic [6:0] div_cnt;
    logic sysclk;
    logic osc_on;
    logic dither;
    logic [6:0] trim;
    logic trim_loaded;
    logic [2:0] ext_mode;
    logic [2:0] ext_bias;
    logic [7:0] rdata;
  } scd_state_s;
endpackage
`default_nettype wire

// *** scd_clock_select_divider.sv ***
// System clock source selection, power-of-two divider and oscillator control registers.
`timescale 1ns/10ps
`default_nettype none

module scd_clock_select_divider
  import scd_pkg::*;
#(
  parameter int NUM_SRC = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [NUM_SRC-1:0] i_osc_clk,
  input wire logic i_int_osc_locked,
  input wire logic i_ext_osc_stable,
  input wire logic [6:0] i_trim_factory,
  output logic [7:0] o_sfr_rdata,
  output logic o_sysclk,
  output logic o_int_osc_on,
  output logic o_dither_on,
  output logic [6:0] o_int_osc_trim,
  output logic [2:0] o_ext_osc_mode_sel,
  output logic [2:0] o_ext_osc_bias_sel
);

  initial begin
    if (NUM_SRC != SCD_NUM_SRC) begin
      $error("Exactly four oscillator sources are supported.");
    end
  end

  // Maps a source code to a source index; bit 2 of the result flags a reserved code.
  function automatic logic [2:0] src_index(input logic [2:0] code);
    logic [2:0] idx;
    idx = 3'h4;
    if (code == SCD_SRC_PRECISION) begin
      idx = 3'h0;
    end else if (code == SCD_SRC_EXTERNAL) begin
      idx = 3'h1;
    end else if (code == SCD_SRC_RTC) begin
      idx = 3'h2;
    end else if (code == SCD_SRC_LOW_POWER) begin
      idx = 3'h3;
    end
    return idx;
  endfunction

  // Decodes a register address into one select bit per register; unmapped addresses give zero.
  function automatic logic [3:0] reg_sel(input logic [7:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    if (addr == SCD_ADDR_SELECT_DIVIDE) begin
      sel = 4'h1;
    end else if (addr == SCD_ADDR_EXT_OSC_CTRL) begin
      sel = 4'h2;
    end else if (addr == SCD_ADDR_INT_OSC_CTRL) begin
      sel = 4'h4;
    end else if (addr == SCD_ADDR_INT_OSC_TRIM) begin
      sel = 4'h8;
    end
    return sel;
  endfunction

  // The wrap value must be the top of a seven-bit count, or a ratio would be applied mid-phase.
  initial begin
    if (SCD_DIV_COUNT_LAST != 7'h7f) begin
      $error("The divide counter must wrap after 128 source edges.");
    end
  end

  // Reset is released through two flops so that every state flop leaves reset on one edge.
  logic rst_meta_r;
  logic rst_sync_r;
  scd_state_s st_r;
  scd_state_s st_nxt;
  scd_sfr_req_s req;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // The bus request travels as one struct, so the decode below reads it from one place.
  assign req = '{wr: i_sfr_wr, rd: i_sfr_rd, addr: i_sfr_addr, wdata: i_sfr_wdata};

  always_comb begin
    logic [3:0] osc_lvl;
    logic [3:0] osc_prev;
    logic cur_lvl;
    logic new_lvl;
    logic new_fall;
    logic src_rise;
    logic gated_lvl;
    logic ext_valid;
    logic freq_ok;
    logic [2:0] idx;
    logic [6:0] cnt_inc;
    logic div_lvl;
    logic [3:0] sel;
    st_nxt = st_r;
    gated_lvl = 1'b0;
    div_lvl = 1'b0;
    osc_lvl = st_r.sync2[3:0];
    osc_prev = st_r.sync_prev[3:0];
    cur_lvl = osc_lvl[st_r.src_cur];
    new_lvl = osc_lvl[st_r.src_new];
    new_fall = osc_prev[st_r.src_new] && !new_lvl;
    src_rise = cur_lvl && !osc_prev[st_r.src_cur];
    cnt_inc = st_r.div_cnt + 7'h01;
    idx = src_index(req.wdata[2:0]);
    sel = reg_sel(req.addr);

    // Oscillator levels and status inputs are asynchronous, so each passes two flops first.
    // The third stage keeps the previous settled level for edge detection.
    st_nxt.sync1 = {i_ext_osc_stable, i_int_osc_locked, i_osc_clk};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync_prev = st_r.sync2;

    // Factory trim is captured once, after reset has been released.
    if (!st_r.trim_loaded) begin
      st_nxt.trim = i_trim_factory;
      st_nxt.trim_loaded = 1'b1;
    end

    // Valid is forced low below the RC mode, which hides the digital clock input modes
    // where the detector has nothing to report.
    ext_valid = st_r.sync2[5] && (st_r.ext_mode >= SCD_EXT_MODE_RC);
    freq_ok = st_r.sync2[4] && st_r.osc_on;

    // Ratio changes land only at the counter wrap, so every output phase stays whole.
    // The price is that a change waits for the next wrap, which can take up to 128 source edges.
    // The counter keeps running while the old source is being left, so its output can fall.
    if ((st_r.sw_state == SCD_SW_RUN || st_r.sw_state == SCD_SW_WAIT_OLD_LOW) && src_rise) begin
      st_nxt.div_cnt = cnt_inc;
      if (st_r.div_cnt == SCD_DIV_COUNT_LAST) begin
        st_nxt.div_applied = st_r.div_sel;
        st_nxt.ready = 1'b1;
      end
    end

    // The level comes from the next counter and ratio, so a ratio change at the wrap
    // cannot leave a one-cycle pulse of the old ratio behind.
    if (st_nxt.div_applied == 3'h0) begin
      div_lvl = cur_lvl;
    end else begin
      div_lvl = st_nxt.div_cnt[st_nxt.div_applied - 3'h1];
    end

    // A switch first waits for the divided output to go low on the old source, then holds
    // it low until the new source falls, so neither source can cut a phase short.
    case (st_r.sw_state)
      SCD_SW_RUN: begin
        if (st_r.src_new != st_r.src_cur) begin
          st_nxt.sw_state = SCD_SW_WAIT_OLD_LOW;
        end
      end
      SCD_SW_WAIT_OLD_LOW: begin
        if (!div_lvl) begin
          st_nxt.sw_state = SCD_SW_WAIT_NEW_LOW;
        end
      end
      SCD_SW_WAIT_NEW_LOW: begin
        // The counter restarts so the first phase on the new source is a whole one.
        if (new_fall) begin
          st_nxt.src_cur = st_r.src_new;
          st_nxt.div_cnt = 7'h00;
          st_nxt.sw_state = SCD_SW_RUN;
        end
      end
      default: begin
        st_nxt.sw_state = SCD_SW_RUN;
      end
    endcase

    if (st_r.sw_state == SCD_SW_WAIT_NEW_LOW || st_nxt.sw_state == SCD_SW_WAIT_NEW_LOW) begin
      gated_lvl = 1'b0;
    end else begin
      gated_lvl = div_lvl;
    end
    st_nxt.sysclk = gated_lvl;

    // Writes to unmapped addresses fall through every branch and change nothing.
    if (req.wr) begin
      if (sel[0]) begin
        st_nxt.div_sel = req.wdata[SCD_POS_DIV_LSB +: 3];
        if (req.wdata[SCD_POS_DIV_LSB +: 3] != st_r.div_sel) begin
          st_nxt.ready = 1'b0;
        end
        // Reserved source codes are ignored and the running source is kept.
        if (!idx[2]) begin
          st_nxt.src_code = req.wdata[2:0];
          st_nxt.src_new = idx[1:0];
        end
      end else if (sel[1]) begin
        st_nxt.ext_mode = req.wdata[SCD_POS_EXT_MODE_LSB +: 3];
        st_nxt.ext_bias = req.wdata[2:0];
      end else if (sel[2]) begin
        st_nxt.osc_on = req.wdata[SCD_POS_OSC_ON];
      end else if (sel[3]) begin
        st_nxt.dither = req.wdata[SCD_POS_DITHER];
        st_nxt.trim = req.wdata[6:0];
        st_nxt.trim_loaded = 1'b1;
      end
    end

    // Read data is registered and held until the next read; unmapped addresses read zero.
    if (req.rd) begin
      if (sel[0]) begin
        st_nxt.rdata = {st_r.ready, st_r.div_sel, 1'b0, st_r.src_code};
      end else if (sel[1]) begin
        st_nxt.rdata = {ext_valid, st_r.ext_mode, 1'b0, st_r.ext_bias};
      end else if (sel[2]) begin
        st_nxt.rdata = {st_r.osc_on, freq_ok, SCD_INT_CTRL_LOW_BITS};
      end else if (sel[3]) begin
        st_nxt.rdata = {st_r.dither, st_r.trim};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r <= '{
        sync1: 6'h00,
        sync2: 6'h00,
        sync_prev: 6'h00,
        div_sel: SCD_RST_DIV,
        div_applied: SCD_RST_DIV,
        ready: 1'b0,
        src_code: SCD_RST_SRC,
        src_cur: 2'h3,
        src_new: 2'h3,
        sw_state: SCD_SW_RUN,
        div_cnt: 7'h00,
        sysclk: 1'b0,
        osc_on: 1'b0,
        dither: 1'b0,
        trim: 7'h00,
        trim_loaded: 1'b0,
        ext_mode: 3'h0,
        ext_bias: 3'h0,
        rdata: 8'h00
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output is a field of the registered state, so none of them can glitch.
  assign o_sfr_rdata = st_r.rdata;
  assign o_sysclk = st_r.sysclk;
  assign o_int_osc_on = st_r.osc_on;
  assign o_dither_on = st_r.dither;
  assign o_int_osc_trim = st_r.trim;
  assign o_ext_osc_mode_sel = st_r.ext_mode;
  assign o_ext_osc_bias_sel = st_r.ext_bias;

endmodule
`default_nettype wire

// *** scd_clock_select_divider_assertions.sv ***
// Checker for the register port and system clock output of the clock select divider.
`timescale 1ns/10ps
`default_nettype none
module scd_clock_select_divider_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sysclk,
  input wire logic o_int_osc_on,
  input wire logic o_dither_on,
  input wire logic [6:0] o_int_osc_trim,
  input wire logic [2:0] o_ext_osc_mode_sel
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire logic rd_sel = i_sfr_rd && i_sfr_addr == 8'ha9;
  wire logic rd_ext = i_sfr_rd && i_sfr_addr == 8'hb1;
  wire logic rd_ctl = i_sfr_rd && i_sfr_addr == 8'hb2;
  wire logic rd_trm = i_sfr_rd && i_sfr_addr == 8'hb3;
  wire logic wr_trm = i_sfr_wr && i_sfr_addr == 8'hb3;
  property p_gap; rd_sel |=> !o_sfr_rdata[3]; endproperty
  a_gap: assert property (p_gap) else $error("select bit 3 set");
  property p_low6; rd_ctl |=> o_sfr_rdata[5:0] == 6'h0f; endproperty
  a_low6: assert property (p_low6) else $error("control low bits");
  property p_on; rd_ctl |=> o_sfr_rdata[7] == $past(o_int_osc_on) && (o_sfr_rdata[7] || !o_sfr_rdata[6]); endproperty
  a_on: assert property (p_on) else $error("control enable read");
  property p_trm_rd; rd_trm |=> o_sfr_rdata == {$past(o_dither_on), $past(o_int_osc_trim)}; endproperty
  a_trm_rd: assert property (p_trm_rd) else $error("trim read");
  property p_trm_wr; wr_trm |=> {o_dither_on, o_int_osc_trim} == $past(i_sfr_wdata); endproperty
  a_trm_wr: assert property (p_trm_wr) else $error("trim write");
  property p_ext; rd_ext && o_ext_osc_mode_sel < 3'h4 |=> !o_sfr_rdata[7]; endproperty
  a_ext: assert property (p_ext) else $error("external valid set");
  // Sources are followed only while each level lasts four or more sampling cycles.
  property p_hi; $rose(o_sysclk) |=> o_sysclk [*3]; endproperty
  a_hi: assert property (p_hi) else $error("short high pulse");
  property p_lo; $fell(o_sysclk) |=> !o_sysclk [*3]; endproperty
  a_lo: assert property (p_lo) else $error("short low pulse");
  c_rdy: cover property (rd_sel ##1 o_sfr_rdata[7]);
  c_ext: cover property (rd_ext ##1 o_sfr_rdata[7]);
  c_clk: cover property ($rose(o_sysclk));
endmodule
bind scd_clock_select_divider scd_clock_select_divider_assertions i_scd_clock_select_divider_assertions (
  .i_clk, .i_rst_n, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .o_sysclk,
  .o_int_osc_on, .o_dither_on, .o_int_osc_trim, .o_ext_osc_mode_sel);
`default_nettype wire

// *** scd_osc_model.sv ***
// Behavioural oscillators with lock and stability indications.
`timescale 1ns/10ps
`default_nettype none
module scd_osc_model (
  input wire logic i_int_osc_on,
  input wire logic [2:0] i_ext_mode,
  output logic [3:0] o_osc_clk,
  output logic o_int_osc_locked,
  output logic o_ext_osc_stable
);
  // Half periods are not multiples of the sampling clock, so the sampled phase drifts.
  for (genvar g = 0; g < 4; g++) begin : g_osc
    initial begin
      o_osc_clk[g] = 1'b0;
      forever #(47 + 36 * g) o_osc_clk[g] = (g > 0 || i_int_osc_on === 1'b1) && !o_osc_clk[g];
    end
  end
  // Digital clock modes 2 and 3 look stable here too, so only the device can hide them.
  initial begin
    o_int_osc_locked = 1'b0;
    o_ext_osc_stable = 1'b0;
    forever begin
      @(i_int_osc_on, i_ext_mode);
      o_int_osc_locked <= #300 i_int_osc_on === 1'b1;
      o_ext_osc_stable <= #500 i_ext_mode >= 3'h2;
    end
  end
endmodule
`default_nettype wire

// *** scd_clock_select_divider_tb.sv ***
// Self-checking bench for the clock select divider.
`timescale 1ns/10ps
`default_nettype none
module scd_clock_select_divider_tb;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, o_sysclk, o_int_osc_on;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, q;
  logic [3:0] i_osc_clk;
  logic i_int_osc_locked, i_ext_osc_stable;
  logic [2:0] o_ext_osc_mode_sel;
  int error_cnt = 0, samples_checked = 0;
  // Address, write data, expected read data and mask of compared bits.
  logic [31:0] rows [14] = '{32'ha904047f, 32'ha906047f, 32'ha90c047f, 32'hb38585ff, 32'hb32a2aff,
    32'hb28fcfff, 32'hb20f0fff, 32'hb12727ff, 32'hb13737ff, 32'hb147c7ff, 32'hb157d7ff,
    32'hb167e7ff, 32'hb10707ff, 32'h005500ff};
  logic [15:0] rsts [4] = '{16'ha934, 16'hb20f, 16'hb351, 16'hb100};
  always #5 i_clk = ~i_clk;
  scd_osc_model i_scd_osc_model (.i_int_osc_on(o_int_osc_on), .i_ext_mode(o_ext_osc_mode_sel),
    .o_osc_clk(i_osc_clk), .o_int_osc_locked(i_int_osc_locked), .o_ext_osc_stable(i_ext_osc_stable));
  scd_clock_select_divider i_scd_clock_select_divider (.i_clk, .i_rst_n, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr,
    .i_sfr_wdata, .i_osc_clk, .i_int_osc_locked, .i_ext_osc_stable, .i_trim_factory(7'h51), .o_sfr_rdata,
    .o_sysclk, .o_int_osc_on, .o_dither_on(), .o_int_osc_trim(), .o_ext_osc_mode_sel, .o_ext_osc_bias_sel());
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_wr <= w;
    i_sfr_rd <= !w;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
    i_sfr_rd <= 1'b0;
    @(negedge i_clk);
    q = o_sfr_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // Measures between the second and third rising edge, so a switch transient is skipped.
  task automatic per(input int e);
    int k, t;
    logic l;
    k = 0;
    t = 0;
    l = 1'b1;
    for (int c = 0; c < 13000 && k < 3; c++) begin
      @(negedge i_clk);
      if (o_sysclk === 1'b1 && l === 1'b0) begin
        k++;
        t = (k == 3) ? c - t : c;
      end
      l = o_sysclk;
    end
    samples_checked++;
    if (k < 3 || t < e - 2 || t > e + 2) begin
      error_cnt++;
      $display("[FAIL] period exp %0d got %0d", e, t);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (rows[i]) begin
      acc(1'b1, rows[i][31:24], rows[i][23:16]);
      repeat (60) @(posedge i_clk);
      acc(1'b0, rows[i][31:24], 8'h00);
      chk("row", rows[i][15:8], q & rows[i][7:0]);
    end
    for (int d = 7; d >= 0; d--) begin
      acc(1'b1, 8'ha9, {1'b0, 3'(d), 4'h4});
      acc(1'b0, 8'ha9, 8'h00);
      chk("pending", 8'h00, q & 8'h80);
      for (int n = 0; n < 2100 && q[7] !== 1'b1; n++) acc(1'b0, 8'ha9, 8'h00);
      chk("applied", 8'h80, q & 8'h80);
      per(31 << d);
    end
    // The divider now stays at divide by one, the setting low-power entry needs.
    acc(1'b0, 8'hb2, 8'h00);
    acc(1'b1, 8'hb2, q | 8'h80);
    acc(1'b1, 8'hb1, 8'h47);
    for (int n = 0; n < 200 && q[7] !== 1'b1; n++) acc(1'b0, 8'hb1, 8'h00);
    chk("valid", 8'h80, q & 8'h80);
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 8'ha9, {5'h00, 3'(s + (s > 1))});
      per((94 + 72 * s) / 10);
    end
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (rsts[i]) begin
      acc(1'b0, rsts[i][15:8], 8'h00);
      chk("reset", rsts[i][7:0], q);
    end
    stop_test();
  end
endmodule
`default_nettype wire
